// ---- logic/conv_consts.vh ----
`ifndef CONV_CONSTS_VH
`define CONV_CONSTS_VH
// printed offsets are byte offsets; not all multiples of four, so each is an index
`define IDX_RESULT_LOW 8'h78
`define IDX_RESULT_HIGH 8'h79
`define IDX_CONTROL_A 8'h7a
`define IDX_CONTROL_B 8'h7b
`define IDX_CHANNEL_REF 8'h7c
// byte address is four times the index
`define ADDR_RESULT_LOW 10'h1e0
`define ADDR_RESULT_HIGH 10'h1e4
`define ADDR_CONTROL_A 10'h1e8
`define ADDR_CONTROL_B 10'h1ec
`define ADDR_CHANNEL_REF 10'h1f0
`define RESET_BYTE 8'h00
// field positions
`define CA_ENABLE 7
`define CA_START 6
`define CA_AUTO 5
`define CA_DONE 4
`define CA_IRQ_EN 3
`define CR_LEFT_ADJ 5
// conversion lengths in converter clocks
`define CONV_FIRST_CYCLES 5'd25
`define CONV_NORMAL_CYCLES 5'd13
`define RESULT_MAX 10'h3ff
`endif

// ---- logic/conv_prescaler.v ----
`timescale 1ns/1ns
// divides hclk into converter clock ticks; one-cycle pulse per converter clock
module conv_prescaler (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run,
  input wire [2:0] clock_prescale_select,
  // tick out
  output reg tick
);
  reg [6:0] count;
  reg [6:0] limit;

  // codes 0 and 1 both divide by two
  always @* begin
    case (clock_prescale_select)
      3'h0, 3'h1: limit = 7'h01;
      3'h2: limit = 7'h03;
      3'h3: limit = 7'h07;
      3'h4: limit = 7'h0f;
      3'h5: limit = 7'h1f;
      3'h6: limit = 7'h3f;
      default: limit = 7'h7f;
    endcase
  end

  // held in reset while idle so each conversion starts on a clean phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= 7'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule

// ---- logic/conv_control.v ----
`timescale 1ns/1ns
`include "conv_consts.vh"
module conv_control (
  // ahb-lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // cpu interrupt side
  input wire global_irq_enable_holder,
  input wire irq_vector_ack,
  output wire conversion_irq,
  // peripheral trigger flags, index = source code, 0 unused
  input wire [7:1] trigger_flags,
  // converter core
  output reg [1:0] reference_select,
  output reg [3:0] channel_select,
  output wire converter_on,
  output reg core_sample,
  output wire core_init_phase,
  input wire [9:0] core_result,
  // comparator mux enable bit out to comparator
  output wire comparator_mux_enable
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [7:0] conv_control_a_reg;
  reg [7:0] conv_control_b_reg;
  reg [7:0] channel_ref_select_reg;
  reg [9:0] conversion_result_bits;
  reg result_locked;
  reg [2:0] state;
  reg [4:0] clk_count;
  reg [4:0] conv_len;
  reg initialized;
  reg [7:1] flag_meta;
  reg [7:1] flag_sync;
  reg trig_level_q;
  reg free_run_restart;
  reg wr_pending;
  reg [9:0] wr_addr;
  reg [9:0] rd_addr;
  reg rd_pending;
  reg [7:0] low_byte;
  reg [7:0] high_byte;
  reg trig_level;
  wire tick;
  wire addr_phase;
  wire converter_enable;
  wire auto_trigger_enable;
  wire conversion_done_flag;
  wire conversion_done_irq_enable;
  wire left_adjust_result;
  wire [2:0] trigger_source_select;
  wire start_write;
  wire done_clear_write;
  wire trigger_edge;
  wire conv_finish;
  wire start_request;

  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign converter_enable = conv_control_a_reg[`CA_ENABLE];
  assign auto_trigger_enable = conv_control_a_reg[`CA_AUTO];
  assign conversion_done_flag = conv_control_a_reg[`CA_DONE];
  assign conversion_done_irq_enable = conv_control_a_reg[`CA_IRQ_EN];
  assign left_adjust_result = channel_ref_select_reg[`CR_LEFT_ADJ];
  assign trigger_source_select = conv_control_b_reg[2:0];
  assign comparator_mux_enable = conv_control_b_reg[6];
  assign converter_on = converter_enable;
  assign core_init_phase = (state == ST_CONV) & ~initialized;

  // interrupt request needs both local and global enables
  assign conversion_irq = conversion_done_flag & conversion_done_irq_enable & global_irq_enable_holder;

  // write strobes decoded in the data phase
  assign start_write = wr_pending & (wr_addr == `ADDR_CONTROL_A) & hwdata[`CA_START];
  assign done_clear_write = wr_pending & (wr_addr == `ADDR_CONTROL_A) & hwdata[`CA_DONE];
  assign conv_finish = (state == ST_CONV) & tick & (clk_count == conv_len - 5'd1);

  // registered address phase so data phase can use hwdata
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      wr_addr <= 10'h000;
      rd_addr <= 10'h000;
    end else begin
      wr_pending <= addr_phase & hwrite;
      rd_pending <= addr_phase & ~hwrite;
      wr_addr <= haddr[9:0];
      rd_addr <= haddr[9:0];
    end
  end

  // trigger flags come from elsewhere; two stages before use
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_meta <= 7'h00;
      flag_sync <= 7'h00;
    end else begin
      flag_meta <= trigger_flags;
      flag_sync <= flag_meta;
    end
  end

  // selected trigger level; code 0 is the done flag itself, never an edge source here
  always @* begin
    if (trigger_source_select == 3'h0) begin
      trig_level = 1'b0;
    end else begin
      trig_level = flag_sync[trigger_source_select];
    end
  end

  // edge compares against last selected level, so a source switch can fire
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_level_q <= 1'b0;
    end else begin
      trig_level_q <= trig_level;
    end
  end

  assign trigger_edge = auto_trigger_enable & converter_enable & trig_level & ~trig_level_q;

  // free run: code zero with auto trigger restarts after each completion
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      free_run_restart <= 1'b0;
    end else begin
      free_run_restart <= conv_finish & auto_trigger_enable & (trigger_source_select == 3'h0);
    end
  end

  assign start_request = (start_write | trigger_edge | free_run_restart) &
                         (converter_enable | (wr_pending & (wr_addr == `ADDR_CONTROL_A) & hwdata[`CA_ENABLE]));

  // conversion sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      clk_count <= 5'd0;
      conv_len <= `CONV_NORMAL_CYCLES;
      initialized <= 1'b0;
      core_sample <= 1'b0;
    end else begin
      core_sample <= 1'b0;
      if (!converter_enable && !(state == ST_IDLE && start_request)) begin
        state <= ST_IDLE;
        clk_count <= 5'd0;
        initialized <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_request) begin
              state <= ST_CONV;
              clk_count <= 5'd0;
              conv_len <= initialized ? `CONV_NORMAL_CYCLES : `CONV_FIRST_CYCLES;
            end
          end
          ST_CONV: begin
            if (tick) begin
              if (clk_count == conv_len - 5'd1) begin
                state <= ST_DONE;
                initialized <= 1'b1;
                core_sample <= 1'b1;
              end else begin
                clk_count <= clk_count + 5'd1;
              end
            end
          end
          // a restart or trigger landing here must not be dropped
          ST_DONE: begin
            if (start_request) begin
              state <= ST_CONV;
              clk_count <= 5'd0;
              conv_len <= `CONV_NORMAL_CYCLES;
            end else begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  conv_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(state == ST_CONV),
    .clock_prescale_select(conv_control_a_reg[2:0]),
    .tick(tick)
  );

  // core delivers a 0..0x3ff code; result captured unless the low byte has been read and the high byte not yet
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_result_bits <= 10'h000;
    end else if (core_sample && !result_locked) begin
      conversion_result_bits <= core_result & `RESULT_MAX;
    end
  end

  // lock set by low read, released by high read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_locked <= 1'b0;
    end else if (rd_pending && rd_addr == `ADDR_RESULT_LOW) begin
      result_locked <= 1'b1;
    end else if (rd_pending && rd_addr == `ADDR_RESULT_HIGH) begin
      result_locked <= 1'b0;
    end
  end

  // mux/reference outputs change only in the idle or done state, so a running conversion keeps its inputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_select <= 2'b00;
      channel_select <= 4'h0;
    end else if ((state == ST_IDLE && !start_request) || state == ST_DONE) begin
      reference_select <= channel_ref_select_reg[7:6];
      channel_select <= channel_ref_select_reg[3:0];
    end
  end

  // software registers; bus write wins except done flag where set beats clear, and start bit which mirrors busy
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_control_a_reg <= `RESET_BYTE;
      conv_control_b_reg <= `RESET_BYTE;
      channel_ref_select_reg <= `RESET_BYTE;
    end else begin
      if (wr_pending && wr_addr == `ADDR_CHANNEL_REF) begin
        channel_ref_select_reg <= {hwdata[7:5], 1'b0, hwdata[3:0]};
      end
      if (wr_pending && wr_addr == `ADDR_CONTROL_B) begin
        conv_control_b_reg <= {1'b0, hwdata[6], 3'b000, hwdata[2:0]};
      end
      if (wr_pending && wr_addr == `ADDR_CONTROL_A) begin
        conv_control_a_reg[7] <= hwdata[7];
        conv_control_a_reg[5] <= hwdata[5];
        conv_control_a_reg[3:0] <= hwdata[3:0];
      end
      // done flag: set on update beats any clear
      if (core_sample) begin
        conv_control_a_reg[`CA_DONE] <= 1'b1;
      end else if (done_clear_write || irq_vector_ack) begin
        conv_control_a_reg[`CA_DONE] <= 1'b0;
      end
      // start bit mirrors busy; a zero write leaves it alone
      conv_control_a_reg[`CA_START] <= (state == ST_CONV) | start_request;
    end
  end

  // justification applied at read time so it follows the bit at once
  always @* begin
    if (left_adjust_result) begin
      high_byte = conversion_result_bits[9:2];
      low_byte = {conversion_result_bits[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, conversion_result_bits[9:8]};
      low_byte = conversion_result_bits[7:0];
    end
  end

  // read data registered in the address phase, valid in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      if (haddr[9:0] == `ADDR_RESULT_LOW) begin
        hrdata <= {24'h000000, low_byte};
      end else if (haddr[9:0] == `ADDR_RESULT_HIGH) begin
        hrdata <= {24'h000000, high_byte};
      end else if (haddr[9:0] == `ADDR_CONTROL_A) begin
        hrdata <= {24'h000000, conv_control_a_reg};
      end else if (haddr[9:0] == `ADDR_CONTROL_B) begin
        hrdata <= {24'h000000, conv_control_b_reg};
      end else if (haddr[9:0] == `ADDR_CHANNEL_REF) begin
        hrdata <= {24'h000000, channel_ref_select_reg};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end
endmodule

// ---- test/conv_control_assertions.sv ----
`timescale 1ns/1ns
module conv_control_assertions (
  // bus side
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  // converter side
  input wire global_irq_enable_holder,
  input wire conversion_irq,
  input wire converter_on,
  input wire core_sample,
  input wire core_init_phase
);
  reg w_q;
  reg r_q;
  reg [9:0] a_q;
  reg [7:0] gap;
  // data-phase view of the last accepted transfer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      r_q <= 1'b0;
      a_q <= 10'h000;
    end else begin
      w_q <= hsel & hready & htrans[1] & hwrite;
      r_q <= hsel & hready & htrans[1] & ~hwrite;
      a_q <= haddr[9:0];
    end
  end
  // cycles since the last sample, saturating so it never wraps
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 8'h00;
    end else if (core_sample) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  irq_gate_a: assert property (conversion_irq |-> global_irq_enable_holder)
    else $error("irq without global enable");
  sample_on_a: assert property (core_sample |-> converter_on)
    else $error("sample while converter off");
  sample_pulse_a: assert property (core_sample |=> !core_sample)
    else $error("sample pulse too long");
  init_off_a: assert property (!converter_on |-> !core_init_phase)
    else $error("init phase while off");
  enable_write_a: assert property ($changed(converter_on) |-> $past(w_q) && $past(a_q) == 10'h1e8)
    else $error("enable changed without write");
  sample_gap_a: assert property (core_sample |-> gap >= 8'd23)
    else $error("conversion too short");
  bit4_zero_a: assert property (r_q && a_q == 10'h1f0 |-> hrdata[4] == 1'b0)
    else $error("unused channel bit read one");
  unmapped_zero_a: assert property (r_q && (a_q[9:2] < 8'h78 || a_q[9:2] > 8'h7c) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// ---- test/conv_core_model.sv ----
`timescale 1ns/1ns
module conv_core_model (
  // clock
  input wire hclk,
  // selection and sample strobe
  input wire [1:0] reference_select,
  input wire [3:0] channel_select,
  input wire core_sample,
  // code out
  output wire [9:0] core_result
);
  reg [9:0] junk = 10'h155;
  // toggles every cycle so a capture outside the strobe cannot match
  always @(posedge hclk) begin
    junk <= ~junk;
  end
  // code follows the live selection, so a premature mux update shows up
  assign core_result = core_sample ? {channel_select, reference_select, 4'h9} : junk;
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg glb = 1'b1;
  reg ack = 1'b0;
  reg [7:1] flags = 7'h00;
  reg [7:0] q;
  wire hready, hresp, irq, on, smp, init, cme;
  wire [31:0] hrdata;
  wire [1:0] rsel;
  wire [3:0] csel;
  wire [9:0] res;
  int cnt;
  int i;
  int fails = 0;
  int n_checks = 0;
  conv_control i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .global_irq_enable_holder(glb), .irq_vector_ack(ack), .conversion_irq(irq),
    .trigger_flags(flags), .reference_select(rsel), .channel_select(csel), .converter_on(on),
    .core_sample(smp), .core_init_phase(init), .core_result(res), .comparator_mux_enable(cme));
  conv_core_model i_core (.hclk(hclk), .reference_select(rsel), .channel_select(csel), .core_sample(smp),
    .core_result(res));
  // 125 mhz system clock
  initial begin
    forever #4 hclk = ~hclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single transfer, holding each phase until hready
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
  endtask
  task rc(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // bounded wait for the end-of-conversion strobe
  task ws(input int lim);
    cnt = 0;
    do begin
      @(negedge hclk);
      cnt = cnt + 1;
    end while (smp !== 1'b1 && cnt < lim);
  endtask
  task go(input logic [7:0] d, input int n, input int dv);
    bus(1'b1, 10'h1e8, d);
    ws(4000);
    chk(cnt >= n * dv - 2 && cnt <= n * dv + dv + 6, 1);
  endtask
  task t_pre;
    int p;
    for (i = 0; i < 6; i = i + 1) rc(10'h1e0 + 10'(4 * i), 8'h00);
    bus(1'b1, 10'h1f0, 8'hd8);
    rc(10'h1f0, 8'hc8);
    chk(csel, 4'h8);
    chk(rsel, 2'h3);
    for (p = 0; p < 8; p = p + 1) begin
      go(8'hd0 | 8'(p), p == 0 ? 25 : 13, p < 2 ? 2 : 1 << p);
      rc(10'h1e8, 8'h90 | 8'(p));
    end
    rc(10'h1e0, 8'h39);
    rc(10'h1e4, 8'h02);
    $display("t_pre done");
  endtask
  task t_sel;
    bus(1'b1, 10'h1e8, 8'hd0);
    rc(10'h1e8, 8'hc0);
    bus(1'b1, 10'h1e8, 8'h80);
    bus(1'b1, 10'h1f0, 8'h41);
    chk(csel, 4'h8);
    rc(10'h1e8, 8'hc0);
    ws(100);
    rc(10'h1e0, 8'h39);
    rc(10'h1e4, 8'h02);
    chk(csel, 4'h1);
    chk(rsel, 2'h1);
    bus(1'b1, 10'h1f0, 8'h61);
    rc(10'h1e0, 8'h40);
    rc(10'h1e4, 8'h8e);
    $display("t_sel done");
  endtask
  task t_lock;
    bus(1'b1, 10'h1f0, 8'h01);
    rc(10'h1e0, 8'h39);
    go(8'hd0, 13, 2);
    rc(10'h1e4, 8'h02);
    rc(10'h1e0, 8'h39);
    rc(10'h1e4, 8'h02);
    go(8'hd0, 13, 2);
    rc(10'h1e0, 8'h49);
    rc(10'h1e4, 8'h00);
    $display("t_lock done");
  endtask
  task t_abort;
    bus(1'b1, 10'h1e8, 8'hd0);
    repeat (10) @(posedge hclk);
    bus(1'b1, 10'h1e8, 8'h00);
    ws(200);
    chk(cnt, 200);
    chk(on, 1'b0);
    rc(10'h1e8, 8'h00);
    go(8'hd0, 25, 2);
    $display("t_abort done");
  endtask
  task t_irq;
    bus(1'b1, 10'h1e8, 8'h88);
    @(negedge hclk);
    chk(irq, 1'b1);
    @(posedge hclk);
    glb <= 1'b0;
    @(negedge hclk);
    chk(irq, 1'b0);
    @(posedge hclk);
    glb <= 1'b1;
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    @(negedge hclk);
    chk(irq, 1'b0);
    rc(10'h1e8, 8'h88);
    $display("t_irq done");
  endtask
  task t_trig;
    bus(1'b1, 10'h1ec, 8'h42);
    @(posedge hclk);
    chk(cme, 1'b1);
    chk(hresp, 1'b0);
    flags <= 7'h02;
    ws(100);
    chk(cnt, 100);
    @(posedge hclk);
    flags <= 7'h00;
    bus(1'b1, 10'h1e8, 8'ha0);
    @(posedge hclk);
    flags <= 7'h02;
    ws(60);
    chk(cnt > 20 && cnt < 60, 1);
    @(posedge hclk);
    flags <= 7'h04;
    repeat (4) @(posedge hclk);
    bus(1'b1, 10'h1ec, 8'h03);
    ws(60);
    chk(cnt < 60, 1);
    bus(1'b1, 10'h1ec, 8'h00);
    ws(100);
    chk(cnt, 100);
    bus(1'b1, 10'h1e8, 8'he0);
    ws(100);
    ws(100);
    chk(cnt >= 24 && cnt <= 34, 1);
    bus(1'b1, 10'h1e8, 8'h80);
    $display("t_trig done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #160000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_pre;
    t_sel;
    t_lock;
    t_abort;
    t_irq;
    t_trig;
    finish_test;
  end
endmodule
bind conv_control conv_control_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .global_irq_enable_holder(global_irq_enable_holder), .conversion_irq(conversion_irq),
  .converter_on(converter_on), .core_sample(core_sample), .core_init_phase(core_init_phase));
